// ---- rtl/uswl_pkg.sv ----
/*
 * Shared constants and types of the serial transceiver with stop-bit,
 * break, wake and wait-time handling: register map, field positions,
 * reset values, frame counts and carrier structs.
 * Assumes a single 10 MHz clock and a synchronous active-low reset.
 */
package uswl_pkg;

	// ==========================================================
	// Register map (word index on the plain register port)
	localparam logic [3:0] USWL_A_CTRL     = 4'h0;
	localparam logic [3:0] USWL_A_BAUD     = 4'h1;
	localparam logic [3:0] USWL_A_TXDATA   = 4'h2;
	localparam logic [3:0] USWL_A_RXDATA   = 4'h3;
	localparam logic [3:0] USWL_A_STAT_LO  = 4'h4;
	localparam logic [3:0] USWL_A_STAT_HI  = 4'h5;
	localparam logic [3:0] USWL_A_PARAM1   = 4'h6;
	localparam logic [3:0] USWL_A_IRQ_STAT = 4'h7;
	localparam logic [3:0] USWL_A_IRQ_MASK = 4'h8;

	localparam int USWL_AW = 4;
	localparam int USWL_DW = 16;

	// ==========================================================
	// Field positions
	localparam int USWL_STHI_TX_WRITE_ERROR_FLAG = 7;
	localparam int USWL_STLO_AVAIL = 0;
	localparam int USWL_STLO_FRAMING_ERROR_FLAG  = 1;
	localparam int USWL_STLO_OVR   = 2;
	localparam int USWL_STLO_BUSY  = 3;
	localparam int USWL_STLO_SLEEP = 4;
	localparam int USWL_TX_LAST    = 8;

	// Interrupt status / mask bits
	localparam int USWL_IRQ_N     = 6;
	localparam int USWL_IRQ_RX    = 0;
	localparam int USWL_IRQ_FRAMING_ERROR_FLAG  = 1;
	localparam int USWL_IRQ_OVR   = 2;
	localparam int USWL_IRQ_TX_WRITE_ERROR_FLAG = 3;
	localparam int USWL_IRQ_WAIT  = 4;
	localparam int USWL_IRQ_WAKE  = 5;

	// ==========================================================
	// Stop-bit select encodings
	localparam logic [1:0] USWL_STOP_TWO_CHK2 = 2'h2;
	localparam logic [1:0] USWL_STOP_TWO_CHK1 = 2'h3;

	// ==========================================================
	// Frame and buffer figures
	localparam int         USWL_DATA_BITS  = 8;
	localparam int         USWL_BREAK_BITS = 13;
	localparam int         USWL_FIFO_DEPTH = 8;
	localparam logic [3:0] USWL_FIFO_FULL  = 4'h8;
	localparam logic [15:0] USWL_BAUD_RST  = 16'h0056;

	typedef struct packed {
		logic [4:0] spare;
		logic       sleep_req;
		logic       smartcard_t1;
		logic       sleep_run_enable;
		logic       wake_enable;
		logic       send_break_bit;
		logic       addr_detect_mode;
		logic       stop_polarity_mode;
		logic [1:0] stop_bit_select;
		logic       rx_en;
		logic       tx_en;
	} uswl_ctrl_s;

	localparam uswl_ctrl_s USWL_CTRL_RST = '0;

	typedef struct packed {
		logic       framing_error_flag;
		logic [7:0] data;
	} uswl_rxent_s;

	typedef struct packed {
		logic       brk;
		logic       two_stop;
		logic [7:0] data;
	} uswl_txreq_s;

	// Two stop bits sent for select values 2 and 3
	function automatic logic uswl_two_stop(input logic [1:0] sel);
		return (sel == USWL_STOP_TWO_CHK2) || (sel == USWL_STOP_TWO_CHK1);
	endfunction

endpackage

// ---- rtl/uswl_rx.sv ----
/*
 * Serial receiver with mid-bit sampling. Checks the first stop bit,
 * and the second one as well when check_two_i is high.
 * Assumes rxd_i is already synchronous to clk_i.
 */
`timescale 1ns/10ps
module uswl_rx import uswl_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	input  wire logic        en_i,
	input  wire logic        rxd_i,
	input  wire logic [15:0] baud_i,
	input  wire logic        check_two_i,
	output logic             start_o,
	output logic             done_o,
	output uswl_rxent_s      ent_o
);
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP1, RX_STOP2} uswl_rxst_e;

	uswl_rxst_e  st_r;
	logic [15:0] div_r;
	logic [2:0]  bit_r;
	logic [7:0]  sh_r;

	// ==========================================================
	// Frame state machine
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_r    <= RX_IDLE;
			div_r   <= '0;
			bit_r   <= '0;
			sh_r    <= '0;
			start_o <= 1'b0;
			done_o  <= 1'b0;
			ent_o   <= '0;
		end else if (ce_i) begin
			start_o <= 1'b0;
			done_o  <= 1'b0;
			if (st_r != RX_IDLE && div_r != '0) begin
				div_r <= div_r - 16'h0001;
			end else begin
				unique case (st_r)
				RX_IDLE: begin
					if (en_i && !rxd_i) begin
						st_r    <= RX_START;
						div_r   <= {1'b0, baud_i[15:1]};
						start_o <= 1'b1;
					end
				end
				RX_START: begin
					// Glitch shorter than half a bit is dropped
					st_r  <= rxd_i ? RX_IDLE : RX_DATA;
					div_r <= baud_i;
					bit_r <= '0;
				end
				RX_DATA: begin
					sh_r  <= {rxd_i, sh_r[7:1]};
					div_r <= baud_i;
					bit_r <= bit_r + 3'h1;
					if (bit_r == 3'(USWL_DATA_BITS - 1))
						st_r <= RX_STOP1;
				end
				RX_STOP1: begin
					ent_o.data <= sh_r;
					ent_o.framing_error_flag <= !rxd_i;
					if (check_two_i) begin
						st_r  <= RX_STOP2;
						div_r <= baud_i;
					end else begin
						st_r   <= RX_IDLE;
						done_o <= 1'b1;
					end
				end
				RX_STOP2: begin
					ent_o.framing_error_flag <= ent_o.framing_error_flag | !rxd_i;
					st_r       <= RX_IDLE;
					done_o     <= 1'b1;
				end
				endcase
			end
		end
	end

endmodule

// ---- rtl/uswl_top.sv ----
/*
 * Serial transceiver top: register port, eight-entry receive buffer,
 * transmit holding register, break sequencing, sleep/wake and the
 * interrupt status, mask and output.
 * Assumes a plain register master: one-cycle strobes, read data in the
 * cycle after the read strobe, serial input synchronous to clk_i.
 */
// How it works
// - Select 2, mode 0: two stops, both checked
// - Select 3: send two stops, check first only
// - Ninth char into full buffer sets overrun, dropped
// - Write-error bit 7 upper status, one clear
// - Disabling transmitter clears write-error bit
// - Address mode: param write with break sends break, content
// - Hardware clears send-break bit after break handled
// - Sleep-run and wake enables both set; reception wakes
// - T=1 wait event only after last-marked character
`timescale 1ns/10ps
module uswl_top import uswl_pkg::*; (
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                ce_i,
	input  wire logic [USWL_AW-1:0]  addr_i,
	input  wire logic [USWL_DW-1:0]  wdata_i,
	input  wire logic                wr_i,
	input  wire logic                rd_i,
	output logic      [USWL_DW-1:0]  rdata_o,
	input  wire logic                rxd_i,
	output logic                     txd_o,
	output logic                     asleep_o,
	output logic                     irq_o
);
	uswl_ctrl_s              ctrl_r;
	logic [15:0]             baud_r;
	logic [7:0]              param1_r;
	logic [8:0]              hold_r;
	logic                    hold_v_r;
	logic                    p1_pend_r;
	logic                    tx_last_r;
	logic                    tx_write_error_flag_r;
	logic                    ovr_r;
	logic [USWL_IRQ_N-1:0]   irq_st_r;
	logic [USWL_IRQ_N-1:0]   irq_mask_r;
	uswl_rxent_s             fifo_r [USWL_FIFO_DEPTH];
	logic [2:0]              wp_r;
	logic [2:0]              rp_r;
	logic [3:0]              cnt_r;

	logic                    wr_ctrl;
	logic                    wr_txd;
	logic                    wr_p1;
	logic                    rd_rxd;
	logic                    rd_irq;
	logic                    pop;
	logic                    push;
	logic                    tx_busy;
	logic                    tx_done;
	logic                    tx_start;
	logic                    tx_brk;
	logic                    tx_from_p1;
	uswl_txreq_s             tx_req;
	logic                    rx_start;
	logic                    rx_done;
	uswl_rxent_s             rx_ent;
	logic                    wake;
	logic                    rx_check_two;
	logic [USWL_IRQ_N-1:0]   irq_set;
	uswl_ctrl_s              wctrl;

	// ==========================================================
	// Access decode
	assign wctrl   = uswl_ctrl_s'(wdata_i);
	assign wr_ctrl = wr_i && addr_i == USWL_A_CTRL;
	assign wr_txd  = wr_i && addr_i == USWL_A_TXDATA;
	assign wr_p1   = wr_i && addr_i == USWL_A_PARAM1;
	assign rd_rxd  = rd_i && addr_i == USWL_A_RXDATA;
	assign rd_irq  = rd_i && addr_i == USWL_A_IRQ_STAT;
	assign pop     = rd_rxd && cnt_r != '0;
	assign push    = rx_done && cnt_r != USWL_FIFO_FULL;

	// ==========================================================
	// Control register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_r <= USWL_CTRL_RST;
		end else if (ce_i) begin
			if (wr_ctrl)
				ctrl_r <= wctrl;
			else if (wake)
				ctrl_r.sleep_req <= 1'b0;
			// Software setting the bit in the same cycle wins
			if (tx_start && tx_brk && !(wr_ctrl && wctrl.send_break_bit))
				ctrl_r.send_break_bit <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			baud_r   <= USWL_BAUD_RST;
			param1_r <= '0;
		end else if (ce_i) begin
			if (wr_i && addr_i == USWL_A_BAUD)
				baud_r <= wdata_i;
			if (wr_p1)
				param1_r <= wdata_i[7:0];
		end
	end

	// ==========================================================
	// Transmit queueing: break first, then parameter, then holding
	assign tx_brk     = ctrl_r.send_break_bit && (p1_pend_r || hold_v_r);
	assign tx_from_p1 = !tx_brk && p1_pend_r;
	assign tx_start   = ctrl_r.tx_en && !tx_busy && (tx_brk || p1_pend_r || hold_v_r);
	assign tx_req     = '{brk:      tx_brk,
	                      two_stop: uswl_two_stop(ctrl_r.stop_bit_select),
	                      data:     tx_from_p1 ? param1_r : hold_r[7:0]};

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			p1_pend_r <= 1'b0;
		end else if (ce_i) begin
			if (!ctrl_r.tx_en)
				p1_pend_r <= 1'b0;
			else if (wr_p1 && ctrl_r.addr_detect_mode)
				p1_pend_r <= 1'b1;
			else if (tx_start && tx_from_p1)
				p1_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			hold_r    <= '0;
			hold_v_r  <= 1'b0;
			tx_last_r <= 1'b0;
		end else if (ce_i) begin
			if (!ctrl_r.tx_en)
				hold_v_r <= 1'b0;
			else if (wr_txd && !hold_v_r) begin
				hold_r   <= wdata_i[8:0];
				hold_v_r <= 1'b1;
			end else if (tx_start && !tx_brk && !tx_from_p1)
				hold_v_r <= 1'b0;
			if (tx_start)
				tx_last_r <= !tx_brk && !tx_from_p1 && hold_r[USWL_TX_LAST];
		end
	end

	// Write error: data written while the holding register is full
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tx_write_error_flag_r <= 1'b0;
		end else if (ce_i) begin
			if (ctrl_r.tx_en && wr_txd && hold_v_r)
				tx_write_error_flag_r <= 1'b1;
			else if (wr_ctrl && !wctrl.tx_en)
				tx_write_error_flag_r <= 1'b0;
			else if (wr_i && addr_i == USWL_A_STAT_HI && wdata_i[USWL_STHI_TX_WRITE_ERROR_FLAG])
				tx_write_error_flag_r <= 1'b0;
		end
	end

	uswl_tx u_tx (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.ce_i    (ce_i),
		.start_i (tx_start),
		.req_i   (tx_req),
		.baud_i  (baud_r),
		.busy_o  (tx_busy),
		.done_o  (tx_done),
		.txd_o   (txd_o)
	);

	// ==========================================================
	// Receiver and buffer
	assign rx_check_two = ctrl_r.stop_bit_select == USWL_STOP_TWO_CHK2
	                      && !ctrl_r.stop_polarity_mode;

	uswl_rx u_rx (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.ce_i        (ce_i),
		.en_i        (ctrl_r.rx_en),
		.rxd_i       (rxd_i),
		.baud_i      (baud_r),
		.check_two_i (rx_check_two),
		.start_o     (rx_start),
		.done_o      (rx_done),
		.ent_o       (rx_ent)
	);

	always_ff @(posedge clk_i) begin
		if (ce_i && push)
			fifo_r[wp_r] <= rx_ent;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else if (ce_i) begin
			if (push)
				wp_r <= wp_r + 3'h1;
			if (pop)
				rp_r <= rp_r + 3'h1;
			cnt_r <= cnt_r + 4'(push) - 4'(pop);
		end
	end

	// Overrun stays until cleared or the buffer is read
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ovr_r <= 1'b0;
		end else if (ce_i) begin
			if (rx_done && cnt_r == USWL_FIFO_FULL)
				ovr_r <= 1'b1;
			else if (pop)
				ovr_r <= 1'b0;
			else if (wr_i && addr_i == USWL_A_STAT_LO && wdata_i[USWL_STLO_OVR])
				ovr_r <= 1'b0;
		end
	end

	// ==========================================================
	// Sleep and wake
	assign asleep_o = ctrl_r.sleep_req;
	assign wake     = ctrl_r.sleep_req && rx_start
	                  && ctrl_r.sleep_run_enable && ctrl_r.wake_enable;

	// ==========================================================
	// Interrupts
	always_comb begin
		irq_set                 = '0;
		irq_set[USWL_IRQ_RX]    = push;
		irq_set[USWL_IRQ_FRAMING_ERROR_FLAG]  = push && rx_ent.framing_error_flag;
		irq_set[USWL_IRQ_OVR]   = rx_done && cnt_r == USWL_FIFO_FULL;
		irq_set[USWL_IRQ_TX_WRITE_ERROR_FLAG] = ctrl_r.tx_en && wr_txd && hold_v_r;
		irq_set[USWL_IRQ_WAIT]  = tx_done && ctrl_r.smartcard_t1 && tx_last_r;
		irq_set[USWL_IRQ_WAKE]  = wake;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_st_r   <= '0;
			irq_mask_r <= '0;
		end else if (ce_i) begin
			irq_st_r <= (rd_irq ? '0 : irq_st_r) | irq_set;
			if (wr_i && addr_i == USWL_A_IRQ_MASK)
				irq_mask_r <= wdata_i[USWL_IRQ_N-1:0];
		end
	end

	assign irq_o = |(irq_st_r & irq_mask_r);

	// ==========================================================
	// Read data, one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else if (ce_i) begin
			rdata_o <= '0;
			if (rd_i) begin
				unique case (addr_i)
				USWL_A_CTRL:     rdata_o <= USWL_DW'(ctrl_r);
				USWL_A_BAUD:     rdata_o <= baud_r;
				USWL_A_TXDATA:   rdata_o <= USWL_DW'(hold_r);
				USWL_A_RXDATA:   rdata_o <= (cnt_r != '0)
				                            ? USWL_DW'(fifo_r[rp_r]) : '0;
				USWL_A_STAT_LO: begin
					rdata_o[USWL_STLO_AVAIL] <= cnt_r != '0;
					rdata_o[USWL_STLO_FRAMING_ERROR_FLAG]  <= cnt_r != '0 && fifo_r[rp_r].framing_error_flag;
					rdata_o[USWL_STLO_OVR]   <= ovr_r;
					rdata_o[USWL_STLO_BUSY]  <= tx_busy || hold_v_r || p1_pend_r;
					rdata_o[USWL_STLO_SLEEP] <= ctrl_r.sleep_req;
				end
				USWL_A_STAT_HI:  rdata_o[USWL_STHI_TX_WRITE_ERROR_FLAG] <= tx_write_error_flag_r;
				USWL_A_PARAM1:   rdata_o <= USWL_DW'(param1_r);
				USWL_A_IRQ_STAT: rdata_o <= USWL_DW'(irq_st_r);
				USWL_A_IRQ_MASK: rdata_o <= USWL_DW'(irq_mask_r);
				default:         rdata_o <= '0;
				endcase
			end
		end
	end

endmodule

// ---- rtl/uswl_tx.sv ----
/*
 * Serial transmitter: one start bit, eight data bits LSB first, one or
 * two stop bits, or a break of eleven low bits followed by two high bits.
 * Assumes the caller starts it only while busy_o is low.
 */
`timescale 1ns/10ps
module uswl_tx import uswl_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	input  wire logic        start_i,
	input  wire uswl_txreq_s req_i,
	input  wire logic [15:0] baud_i,
	output logic             busy_o,
	output logic             done_o,
	output logic             txd_o
);
	logic [15:0] div_r;
	logic [4:0]  left_r;
	logic [11:0] shift_r;

	// ==========================================================
	// Bit timing and shifting
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			div_r   <= '0;
			left_r  <= '0;
			shift_r <= '1;
			busy_o  <= 1'b0;
			done_o  <= 1'b0;
			txd_o   <= 1'b1;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (!busy_o) begin
				if (start_i) begin
					busy_o <= 1'b1;
					div_r  <= baud_i;
					txd_o  <= 1'b0;
					if (req_i.brk) begin
						shift_r <= 12'h800;
						left_r  <= 5'(USWL_BREAK_BITS);
					end else begin
						shift_r <= {2'b11, 1'b1, req_i.data, 1'b0};
						left_r  <= req_i.two_stop ? 5'(USWL_DATA_BITS + 3)
						                          : 5'(USWL_DATA_BITS + 2);
					end
				end
			end else if (div_r != '0) begin
				div_r <= div_r - 16'h0001;
			end else begin
				div_r <= baud_i;
				if (left_r == 5'h01) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
					txd_o  <= 1'b1;
				end else begin
					shift_r <= {1'b1, shift_r[11:1]};
					txd_o   <= shift_r[1];
				end
				left_r <= left_r - 5'h01;
			end
		end
	end

endmodule

// ---- testbench/uswl_monitor.sv ----
/*
 * Checker of the transceiver top: register port, interrupt, sleep and
 * serial bit-time relations.
 * Assumes only the top ports are visible; bound after the module.
 */
`timescale 1ns/10ps
module uswl_monitor import uswl_pkg::*; (
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	input  wire logic               ce_i,
	input  wire logic [USWL_AW-1:0] addr_i,
	input  wire logic [USWL_DW-1:0] wdata_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	input  wire logic [USWL_DW-1:0] rdata_o,
	input  wire logic               rxd_i,
	input  wire logic               txd_o,
	input  wire logic               asleep_o,
	input  wire logic               irq_o
);
	// ==========================================================
	// Helper: shadow bit time and length of the current low run
	logic        rdq;
	logic        wrq;
	logic [15:0] baud_r;
	logic [15:0] low_r;
	assign rdq = rd_i && ce_i;
	assign wrq = wr_i && ce_i;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			baud_r <= USWL_BAUD_RST;
		else if (wrq && addr_i == USWL_A_BAUD)
			baud_r <= wdata_i;
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || txd_o)
			low_r <= '0;
		else if (low_r != 16'hffff)
			low_r <= low_r + 16'h0001;
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_rdata_idle: assert property ($past(!rdq) |-> rdata_o == '0)
		else $error("read data not zero outside read cycle");
	a_unmapped_read: assert property (rdq && addr_i > USWL_A_IRQ_MASK |=> rdata_o == '0)
		else $error("unmapped read not zero");
	a_irq_read: assert property (rdq && addr_i == USWL_A_IRQ_STAT && irq_o |=> rdata_o != '0)
		else $error("interrupt high but status read empty");
	a_irq_mask_off: assert property (wrq && addr_i == USWL_A_IRQ_MASK && wdata_i == '0
		|=> !irq_o) else $error("interrupt high with mask zero");
	a_mask_back: assert property (wrq && addr_i == USWL_A_IRQ_MASK ##2
		rdq && addr_i == USWL_A_IRQ_MASK |=> rdata_o[USWL_IRQ_N-1:0] ==
		$past(wdata_i[USWL_IRQ_N-1:0], 3)) else $error("mask read back wrong");
	a_tx_write_error_flag_clear: assert property (wrq && addr_i == USWL_A_STAT_HI &&
		wdata_i[USWL_STHI_TX_WRITE_ERROR_FLAG] ##1 !wr_i ##1 rdq && addr_i == USWL_A_STAT_HI
		|=> !rdata_o[USWL_STHI_TX_WRITE_ERROR_FLAG]) else $error("write error not cleared");
	a_txdis_clear: assert property (wrq && addr_i == USWL_A_CTRL && !wdata_i[0]
		##1 !wr_i ##1 rdq && addr_i == USWL_A_STAT_HI
		|=> !rdata_o[USWL_STHI_TX_WRITE_ERROR_FLAG]) else $error("write error kept after disable");
	a_sleep_rise: assert property ($rose(asleep_o)
		|-> $past(wrq && addr_i == USWL_A_CTRL && wdata_i[10]))
		else $error("sleep entered without request");
	a_bit_time: assert property ($rose(txd_o) |-> low_r >= baud_r + 16'h0001)
		else $error("serial low run shorter than one bit");

	c_rx_read: cover property (rdq && addr_i == USWL_A_RXDATA);
	c_wake: cover property ($fell(asleep_o));
	c_irq: cover property (irq_o ##1 !irq_o);
endmodule

bind uswl_top uswl_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.rxd_i(rxd_i), .txd_o(txd_o), .asleep_o(asleep_o), .irq_o(irq_o));

// ---- testbench/uswl_remote.sv ----
/*
 * Remote serial transceiver: sends frames with chosen stop levels and
 * decodes the device's output, breaks included.
 * Assumes an idle-high line and BT clocks per bit.
 */
`timescale 1ns/10ps
module uswl_remote #(
	parameter int BT = 4
) (
	input  wire logic clk_i,
	input  wire logic txd_i,
	output logic      rxd_o
);
	logic [8:0] q[$];
	int         gap = 0;
	int         t_now = 0;
	int         t_st = 0;
	logic [7:0] sh;

	initial rxd_o = 1'b1;
	always @(posedge clk_i) t_now <= t_now + 1;

	// ==========================================================
	// Send: start, eight data bits LSB first, two stop levels
	task automatic send(input logic [7:0] d, input logic s1, input logic s2);
		logic [10:0] f;
		f = {s2, s1, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd_o <= f[i];
			repeat (BT) @(posedge clk_i);
		end
		// One idle clock so a following frame never drives the line in the same step
		rxd_o <= 1'b1;
		@(posedge clk_i);
	endtask

	// ==========================================================
	// Decode: entry [8] marks a break, gap is start-to-start clocks
	always begin
		@(negedge txd_i);
		gap = t_now - t_st;
		t_st = t_now;
		repeat (BT / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BT) @(posedge clk_i);
			sh[i] = txd_i;
		end
		repeat (BT) @(posedge clk_i);
		q.push_back({!txd_i && sh == 8'h00, sh});
		while (!txd_i) @(posedge clk_i);
	end
endmodule

// ---- testbench/uswl_stop_break_wake_logic_tb.sv ----
/*
 * Testbench of the transceiver top: register tasks, remote model on the
 * serial pins and a scenario sequence with expected values.
 * Assumes bit time BAUD+1 clocks, BAUD set to 3.
 */
`timescale 1ns/10ps
module uswl_stop_break_wake_logic_tb import uswl_pkg::*;;
	logic               clk_i = 1'b0;
	logic               rst_n_i = 1'b0;
	logic               ce_i = 1'b1;
	logic [USWL_AW-1:0] addr_i = '0;
	logic [USWL_DW-1:0] wdata_i = '0;
	logic               wr_i = 1'b0;
	logic               rd_i = 1'b0;
	logic [USWL_DW-1:0] rdata_o;
	logic               rxd_i;
	logic               txd_o;
	logic               asleep_o;
	logic               irq_o;
	logic [USWL_DW-1:0] v;
	int                 mismatches = 0;
	int                 cmp_count = 0;

	always #50 clk_i = ~clk_i;

	uswl_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i),
		.txd_o(txd_o), .asleep_o(asleep_o), .irq_o(irq_o));
	uswl_remote #(.BT(4)) P (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

	// ==========================================================
	// Tasks
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	task automatic rc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e,
		input string n);
		logic [15:0] d;
		rd(a, d);
		chk(n, d & m, e);
	endtask

	task automatic wait_bit(input int b, input logic val);
		logic [15:0] d;
		for (int i = 0; i < 500; i++) begin
			rd(USWL_A_STAT_LO, d);
			if (d[b] === val)
				return;
		end
		mismatches++;
		wrap_up();
	endtask

	initial begin
		#3ms;
		mismatches++;
		wrap_up();
	end

	// ==========================================================
	// Scenarios
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rc(USWL_A_BAUD, 16'hffff, USWL_BAUD_RST, "baud reset");
		rc(USWL_A_CTRL, 16'hffff, 16'h0000, "ctrl reset");
		rc(4'h9, 16'hffff, 16'h0000, "unmapped");
		wr(USWL_A_BAUD, 16'h0003);
		wr(USWL_A_IRQ_MASK, 16'h0000);
		$display("test reset done");

		wr(USWL_A_CTRL, 16'h000b);
		P.send(8'ha5, 1'b1, 1'b0);
		wait_bit(USWL_STLO_AVAIL, 1'b1);
		rc(USWL_A_STAT_LO, 16'h0002, 16'h0002, "head framing_error_flag");
		rc(USWL_A_RXDATA, 16'h01ff, 16'h01a5, "sel2 one stop");
		P.send(8'h3c, 1'b1, 1'b1);
		wait_bit(USWL_STLO_AVAIL, 1'b1);
		rc(USWL_A_RXDATA, 16'h01ff, 16'h003c, "sel2 two stops");
		wr(USWL_A_CTRL, 16'h000f);
		P.send(8'h5a, 1'b1, 1'b0);
		wait_bit(USWL_STLO_AVAIL, 1'b1);
		rc(USWL_A_RXDATA, 16'h01ff, 16'h005a, "sel3 one stop");
		// Low second stop looks like a new start: drain that frame
		wait_bit(USWL_STLO_AVAIL, 1'b1);
		rd(USWL_A_RXDATA, v);
		chk("irq masked", {15'h0000, irq_o}, 16'h0000);
		$display("test stop checks done");

		for (int i = 0; i < 9; i++)
			P.send(8'h40 + i[7:0], 1'b1, 1'b1);
		repeat (8) @(posedge clk_i);
		rc(USWL_A_STAT_LO, 16'h0004, 16'h0004, "overrun");
		for (int i = 0; i < 8; i++)
			rc(USWL_A_RXDATA, 16'h01ff, 16'h0040 + 16'(i), "buffered char");
		rc(USWL_A_STAT_LO, 16'h0005, 16'h0000, "ninth dropped");
		$display("test overrun done");

		P.q.delete();
		for (int k = 0; k < 2; k++) begin
			wr(USWL_A_TXDATA, 16'h0011);
			wr(USWL_A_TXDATA, 16'h0022);
			wr(USWL_A_TXDATA, 16'h0033);
			wait_bit(USWL_STLO_BUSY, 1'b0);
			rc(USWL_A_STAT_HI, 16'h0080, 16'h0080, "write error set");
			if (k == 0) begin
				repeat (20) @(posedge clk_i);
				chk("tx count", 16'(P.q.size()), 16'h0002);
				chk("tx first", {7'h00, P.q[0]}, 16'h0011);
				chk("tx second", {7'h00, P.q[1]}, 16'h0022);
				chk("two stops", {15'h0000, P.gap >= 44}, 16'h0001);
				rc(USWL_A_IRQ_STAT, 16'h0008, 16'h0008, "write error irq");
				wr(USWL_A_STAT_HI, 16'h0080);
			end else
				wr(USWL_A_CTRL, 16'h000e);
			rc(USWL_A_STAT_HI, 16'h0080, 16'h0000, "write error cleared");
		end
		$display("test write error done");

		P.q.delete();
		wr(USWL_A_CTRL, 16'h0061);
		wr(USWL_A_PARAM1, 16'h005a);
		wait_bit(USWL_STLO_BUSY, 1'b0);
		repeat (20) @(posedge clk_i);
		chk("break", {7'h00, P.q[0]}, 16'h0100);
		chk("param after break", {7'h00, P.q[1]}, 16'h005a);
		rc(USWL_A_CTRL, 16'h0040, 16'h0000, "break bit");
		$display("test break done");

		wr(USWL_A_CTRL, 16'h0201);
		rd(USWL_A_IRQ_STAT, v);
		for (int k = 0; k < 2; k++) begin
			wr(USWL_A_TXDATA, k ? 16'h0122 : 16'h0011);
			wait_bit(USWL_STLO_BUSY, 1'b0);
			repeat (4) @(posedge clk_i);
			rc(USWL_A_IRQ_STAT, 16'h0010, k ? 16'h0010 : 16'h0000, "wait event");
		end
		$display("test wait event done");

		wr(USWL_A_CTRL, 16'h0482);
		P.send(8'h66, 1'b1, 1'b1);
		repeat (4) @(posedge clk_i);
		#1;
		chk("stays asleep", {15'h0000, asleep_o}, 16'h0001);
		rd(USWL_A_RXDATA, v);
		wr(USWL_A_IRQ_MASK, 16'h0020);
		rc(USWL_A_IRQ_MASK, 16'h003f, 16'h0020, "mask back");
		rd(USWL_A_IRQ_STAT, v);
		wr(USWL_A_CTRL, 16'h0582);
		#1;
		chk("irq before wake", {15'h0000, irq_o}, 16'h0000);
		P.send(8'h77, 1'b1, 1'b1);
		repeat (4) @(posedge clk_i);
		#1;
		chk("woken", {15'h0000, asleep_o}, 16'h0000);
		chk("irq raised", {15'h0000, irq_o}, 16'h0001);
		rc(USWL_A_IRQ_STAT, 16'h0020, 16'h0020, "wake irq");
		chk("irq cleared", {15'h0000, irq_o}, 16'h0000);
		rc(USWL_A_RXDATA, 16'h01ff, 16'h0077, "char after wake");
		wr(USWL_A_IRQ_MASK, 16'h0000);
		$display("test wake done");
		wrap_up();
	end
endmodule
